// *** hdl/body_rate_attitude_estimator.sv ***
// Purpose: body rate and attitude angle estimator for the entry phase
// Assumes: all inputs synchronous to core_clk; fresh reference angles computed outside
// Notes:   angles are wrapping turns; trig from a parabolic sine approximation
// Notes on behaviour
// [R1] every 2 s a fresh attitude reference is requested and loaded from navigation
// [R2] gimbal angles are latched at the accelerometer read instant for the triad
// [R3] fresh angles plus increment integrated since the read replace running angles
// [R4] attitude rates integrated every 0.1 s to keep roll, yaw, pitch current
// [R5] below 1000 ft/s the trajectory normal vector freezes for the rest of flight
// [R6] corrected body rates go to all users; gamma correction only above minimum
// [R7] body rates are computed on a 0.1 s cycle
// [R8] gimbal increment is present encoder angle minus previous cycle's angle
// [R9] corrected increment is present plus half of present minus previous
// [R10] previous raw transformed increment is stored, never the averaged one
// [R11] zero gimbals give roll, pitch, yaw equal outer, inner, middle rates
// [R12] flight path rate correction uses trim pitch constant, not estimated pitch
// [R13] attitude integration skipped while the autopilot is in standby
// [R14] reference load and periodic integration merge in one cycle, nothing lost
// [R15] roll attitude action scaled by cosine of pitch, rate damping kept
// [R16] yaw coordination uses trim pitch, not the on-board pitch estimate
// [R17] attitude angles wrap as fixed-point turns without overflow faults
`timescale 1ns/1ns
module body_rate_attitude_estimator
    import attitude_estimator_pkg::*;
#(
    parameter int          TICK_CYCLES = RATE_CYCLES,
    parameter int          REF_COUNT   = REF_TICKS,
    parameter logic [15:0] VEL_FREEZE  = VEL_FREEZE_FPS,
    parameter logic [15:0] ALPHA_TRIM  = ALPHA_TRIM_DEFAULT,
    parameter logic [15:0] GAMMA_MIN   = GAMMA_MIN_DEFAULT
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire gimbal_t    gimbal,
    input  wire logic       autopilot_standby,
    input  wire logic       fresh_valid,
    input  wire attitude_t  fresh_angles,
    input  wire logic [15:0] rel_velocity_mag,
    input  wire vec3_t      traj_normal_in,
    input  wire incr_t      gamma_dot,
    input  wire incr_t      roll_attitude_error,
    output logic            nav_cycle_start,
    output gimbal_t         latched_gimbal,
    output body_rate_t      body_rates,
    output logic            rates_valid,
    output attitude_t       attitude,
    output vec3_t           traj_normal,
    output logic            normal_frozen,
    output incr_t           roll_attitude_gain,
    output incr_t           roll_attitude_action,
    output incr_t           yaw_coord_error
);

    generate
        if (TICK_CYCLES < MIN_TICK_CYCLES || REF_COUNT < 2 || REF_COUNT > MAX_REF_TICKS)
        begin : g_bad_params
            $error("tick or reference count out of range");
        end
        if (GAMMA_MIN[15]) begin : g_bad_gamma
            $error("flight path rate minimum must not be negative");
        end
    endgenerate

    // parabolic sine of a 16-bit turn, result scaled by 2^14
    function automatic incr_t sinq(input angle_t a);
        logic [31:0] x;
        logic [31:0] prod;
        incr_t       s;
        x    = {17'h0, a[14:0]};
        prod = x * ({16'h0, HALF_TURN_SPAN} - x);
        s    = incr_t'(prod[29:14]);
        return a[15] ? incr_t'(-s) : s;
    endfunction

    // cosine as the sine a quarter turn further on
    function automatic incr_t cosq(input angle_t a);
        angle_t shifted;
        shifted = a + QUARTER_TURN;
        return sinq(shifted);
    endfunction

    // product of two values with 14 fraction bits, truncated
    function automatic incr_t mulq(input incr_t a, input incr_t b);
        logic signed [31:0] p;
        p = a * b;
        return incr_t'(p[FRAC_BITS +: 16]);
    endfunction

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
    localparam logic [7:0]  REF_LAST  = 8'(REF_COUNT - 1);
    // trim pitch sine and cosine fixed at elaboration
    localparam incr_t       S_TRIM    = sinq(ALPHA_TRIM);
    localparam incr_t       C_TRIM    = cosq(ALPHA_TRIM);

    // tick timing
    logic [31:0]      tick_count;
    logic [7:0]       ref_count;
    estimator_state_t state;
    estimator_state_t next_state;
    logic             primed;

    // tick_count paces the rate cycle, ref_count the reference cycle
    wire        tick_done       = tick_count == TICK_LAST;
    wire        ref_due         = tick_done && (ref_count == REF_LAST);
    wire [31:0] next_tick_count = tick_done ? 32'h0 : tick_count + 32'h1;
    wire [7:0]  next_ref_count  = ref_due ? 8'h0 : ref_count + 8'h1;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tick_count <= 32'h0;
            ref_count  <= 8'h0;
        end else begin
            tick_count <= next_tick_count;                         // [R7]
            if (tick_done) begin
                ref_count <= next_ref_count;                       // [R1]
            end
        end
    end

    // first tick after reset only primes the gimbal history
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  next_state = tick_done ? ST_DIFF : ST_IDLE;  // [R7]
            ST_DIFF:  next_state = primed ? ST_XFORM : ST_IDLE;
            ST_XFORM: next_state = ST_AVG;
            ST_AVG:   next_state = autopilot_standby ? ST_IDLE : ST_INTEG; // [R13]
            ST_INTEG: next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // reference request and gimbal latch at the read instant
    // the triad uses these gimbals, not the ones current at the update
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            nav_cycle_start <= 1'b0;
            latched_gimbal  <= '0;
        end else begin
            nav_cycle_start <= ref_due;                            // [R1]
            if (ref_due) begin
                latched_gimbal <= gimbal;                          // [R2]
            end
        end
    end

    // gimbal differencing and trig capture
    // increments wrap modulo a turn, so crossing zero stays small
    // trig taken from the same sample and held until the next tick
    gimbal_t gimbal_prev;
    gimbal_t gimbal_incr;
    incr_t   sin_mid;
    incr_t   cos_mid;
    incr_t   sin_out;
    incr_t   cos_out;

    wire gimbal_t next_gimbal_incr = {gimbal.outer  - gimbal_prev.outer,
                                      gimbal.inner  - gimbal_prev.inner,
                                      gimbal.middle - gimbal_prev.middle}; // [R8]

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gimbal_prev <= '0;
            gimbal_incr <= '0;
            primed      <= 1'b0;
            sin_mid     <= INCR_RESET;
            cos_mid     <= INCR_RESET;
            sin_out     <= INCR_RESET;
            cos_out     <= INCR_RESET;
        end else if (state == ST_DIFF) begin
            gimbal_prev <= gimbal;                                 // [R8]
            gimbal_incr <= next_gimbal_incr;
            primed      <= 1'b1;
            sin_mid     <= sinq(gimbal.middle);
            cos_mid     <= cosq(gimbal.middle);
            sin_out     <= sinq(gimbal.outer);
            cos_out     <= cosq(gimbal.outer);
        end
    end

    // gimbal to body rate transform
    // zero gimbals leave roll, pitch, yaw equal to outer, inner, middle
    body_rate_t raw_now;
    body_rate_t raw_prev;

    wire incr_t d_outer  = incr_t'(gimbal_incr.outer);
    wire incr_t d_inner  = incr_t'(gimbal_incr.inner);
    wire incr_t d_middle = incr_t'(gimbal_incr.middle);
    wire incr_t inner_cm = mulq(d_inner, cos_mid);

    wire body_rate_t next_raw = {
        incr_t'(d_outer + mulq(d_inner, sin_mid)),                 // [R11]
        incr_t'(mulq(inner_cm, cos_out) + mulq(d_middle, sin_out)),
        incr_t'(mulq(d_middle, cos_out) - mulq(inner_cm, sin_out))
    };

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            raw_now <= '0;
        end else if (state == ST_XFORM) begin
            raw_now <= next_raw;
        end
    end

    // constant acceleration correction per axis
    // the previous raw transform is kept, never the averaged value
    // 17-bit difference keeps the halving free of overflow
    body_rate_t avg_rate;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_axis_avg
            wire incr_t              cur  = raw_now[16*i +: 16];
            wire incr_t              old  = raw_prev[16*i +: 16];
            wire logic signed [16:0] diff = {cur[15], cur} - {old[15], old};
            wire logic signed [16:0] sum  = {cur[15], cur} + (diff >>> 1);  // [R9]
            assign avg_rate[16*i +: 16] = sum[15:0];
        end
    endgenerate

    // flight path rate correction with trim pitch
    // trim pitch keeps state vector error out of the corrected rates
    // below the minimum the correction is left out entirely
    wire incr_t sin_roll   = sinq(attitude.roll);
    wire incr_t cos_roll   = cosq(attitude.roll);
    wire incr_t gamma_mag  = gamma_dot[15] ? incr_t'(-gamma_dot) : gamma_dot;
    wire logic  gamma_on   = gamma_mag > incr_t'(GAMMA_MIN);                // [R6]
    wire incr_t gamma_used = gamma_on ? gamma_dot : incr_t'(INCR_RESET);
    wire incr_t corr_roll  = mulq(mulq(S_TRIM, sin_roll), gamma_used);     // [R12]
    wire incr_t corr_pitch = mulq(cos_roll, gamma_used);
    wire incr_t corr_yaw   = mulq(mulq(C_TRIM, sin_roll), gamma_used);     // [R12]

    wire body_rate_t next_rates = {
        incr_t'(avg_rate.roll - corr_roll),
        incr_t'(avg_rate.pitch - corr_pitch),
        incr_t'(avg_rate.yaw + corr_yaw)
    };

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            raw_prev    <= '0;
            body_rates  <= '0;
            rates_valid <= 1'b0;
        end else begin
            // rates and their strobe leave on the same edge
            rates_valid <= state == ST_AVG;
            if (state == ST_AVG) begin
                raw_prev   <= raw_now;                             // [R10]
                body_rates <= next_rates;                          // [R6]
            end
        end
    end

    // attitude rate integration
    // runs the cycle after the rates, never on a tick edge
    wire incr_t sin_pitch = sinq(attitude.pitch);
    wire incr_t cos_pitch = cosq(attitude.pitch);
    wire incr_t sin_yaw   = sinq(attitude.yaw);
    wire incr_t roll_by_cos = mulq(body_rates.roll, cos_pitch);
    wire incr_t yaw_by_sin  = mulq(body_rates.yaw, sin_pitch);
    wire incr_t roll_by_sin = mulq(body_rates.roll, sin_pitch);
    wire incr_t yaw_by_cos  = mulq(body_rates.yaw, cos_pitch);
    wire incr_t rate_roll   = incr_t'(roll_by_cos + yaw_by_sin);
    wire incr_t rate_yaw    = incr_t'(roll_by_sin + yaw_by_cos);
    wire incr_t rate_pitch = incr_t'(body_rates.pitch + mulq(rate_roll, sin_yaw));

    wire logic      integ_fire = state == ST_INTEG;                // [R13]
    wire attitude_t att_delta  = integ_fire ? {rate_roll, rate_yaw, rate_pitch}
                                            : '0;              // [R4]

    // reference load and step add in one cycle, so no increment is lost
    // since_read restarts at the read instant the reference belongs to
    attitude_t since_read;
    attitude_t next_attitude;
    attitude_t next_since_read;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_axis_att
            wire angle_t cur   = attitude[16*i +: 16];
            wire angle_t acc   = since_read[16*i +: 16];
            wire angle_t fresh = fresh_angles[16*i +: 16];
            wire angle_t step  = att_delta[16*i +: 16];
            wire angle_t base  = fresh_valid ? fresh + acc : cur;  // [R3]
            assign next_attitude[16*i +: 16]   = base + step;      // [R14]
            assign next_since_read[16*i +: 16] = ref_due ? ANGLE_RESET : acc + step; // [R17]
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            attitude   <= '0;
            since_read <= '0;
        end else begin
            attitude   <= next_attitude;                           // [R4]
            since_read <= next_since_read;                         // [R3]
        end
    end

    // trajectory normal vector hold
    // the vector from before the slow update stays for the rest of flight
    // only a reset clears the freeze
    wire logic low_velocity = rel_velocity_mag < VEL_FREEZE;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            traj_normal   <= '0;
            normal_frozen <= 1'b0;
        end else if (fresh_valid && !normal_frozen) begin
            if (low_velocity) begin
                normal_frozen <= 1'b1;                             // [R5]
            end else begin
                traj_normal <= traj_normal_in;
            end
        end
    end

    // control path helpers
    // cos(pitch) near zero drops attitude action, rate damping untouched
    // yaw coordination from trim pitch so jets do not chase a bad estimate
    wire incr_t next_roll_action = mulq(roll_attitude_error, cos_pitch);  // [R15]
    wire incr_t next_yaw_coord   = incr_t'(mulq(body_rates.yaw, C_TRIM)
                                           - mulq(body_rates.roll, S_TRIM)); // [R16]

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            roll_attitude_gain   <= INCR_RESET;
            roll_attitude_action <= INCR_RESET;
            yaw_coord_error      <= INCR_RESET;
        end else begin
            roll_attitude_gain   <= cos_pitch;                     // [R15]
            roll_attitude_action <= next_roll_action;
            yaw_coord_error      <= next_yaw_coord;
        end
    end

endmodule

// *** hdl/attitude_estimator_pkg.sv ***
// Purpose: shared constants and carriers for the body rate and attitude estimator
// Assumes: angles are unsigned turns over 16 bits, trig values signed with 14 fraction bits
// Notes:   timing figures are kept in their own units and turned into cycles or rate ticks here
package attitude_estimator_pkg;

    localparam int CLK_PERIOD_NS  = 4;
    localparam int NS_PER_MS      = 1000000;
    localparam int RATE_PERIOD_MS = 100;
    localparam int REF_PERIOD_MS  = 2000;
    localparam int RATE_CYCLES    = RATE_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int REF_TICKS      = REF_PERIOD_MS / RATE_PERIOD_MS;
    localparam int MIN_TICK_CYCLES = 8;
    localparam int MAX_REF_TICKS  = 255;

    localparam int              FRAC_BITS          = 14;
    localparam logic [15:0]     QUARTER_TURN       = 16'h4000;
    localparam logic [15:0]     HALF_TURN_SPAN     = 16'h8000;
    localparam logic [15:0]     VEL_FREEZE_FPS     = 16'h03E8;
    localparam logic [15:0]     ALPHA_TRIM_DEFAULT = 16'hF000;
    localparam logic [15:0]     GAMMA_MIN_DEFAULT  = 16'h0010;
    localparam logic [15:0]     ANGLE_RESET        = 16'h0000;
    localparam logic [15:0]     INCR_RESET         = 16'h0000;

    typedef logic        [15:0] angle_t;
    typedef logic signed [15:0] incr_t;

    typedef struct packed {
        angle_t outer;
        angle_t inner;
        angle_t middle;
    } gimbal_t;

    typedef struct packed {
        incr_t roll;
        incr_t pitch;
        incr_t yaw;
    } body_rate_t;

    typedef struct packed {
        angle_t roll;
        angle_t yaw;
        angle_t pitch;
    } attitude_t;

    typedef struct packed {
        incr_t x;
        incr_t y;
        incr_t z;
    } vec3_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DIFF,
        ST_XFORM,
        ST_AVG,
        ST_INTEG
    } estimator_state_t;

endpackage

// *** sim/estimator_props.sv ***
// Purpose: port checks for the estimator
// Assumes: bound into every estimator instance
// Notes:   gap counters measure pulse spacing
`timescale 1ns/1ns
module estimator_props
    import attitude_estimator_pkg::*;
#(
    parameter int TICK_CYCLES = 32,
    parameter int REF_COUNT   = 5
) (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       autopilot_standby,
    input wire logic       fresh_valid,
    input wire logic       nav_cycle_start,
    input wire gimbal_t    latched_gimbal,
    input wire body_rate_t body_rates,
    input wire logic       rates_valid,
    input wire attitude_t  attitude,
    input wire vec3_t      traj_normal,
    input wire logic       normal_frozen
);
    int   rv_gap;
    int   nav_gap;
    logic rv_seen;
    logic nav_seen;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rv_gap   <= 0;
            nav_gap  <= 0;
            rv_seen  <= 1'b0;
            nav_seen <= 1'b0;
        end else begin
            rv_gap   <= rates_valid ? 0 : rv_gap + 1;
            nav_gap  <= nav_cycle_start ? 0 : nav_gap + 1;
            rv_seen  <= rv_seen | rates_valid;
            nav_seen <= nav_seen | nav_cycle_start;
        end
    end
    sequence s_rates_after_nav;
        ##3 rates_valid;
    endsequence
    property p_nav_rates;
        nav_cycle_start |-> s_rates_after_nav;
    endproperty
    a_nav_rates: assert property (p_nav_rates) else $error("no rates after read");
    property p_rv_spacing;
        rates_valid && rv_seen |-> rv_gap == TICK_CYCLES - 1;
    endproperty
    a_rv_spacing: assert property (p_rv_spacing) else $error("rate spacing wrong");
    property p_nav_spacing;
        nav_cycle_start && nav_seen |-> nav_gap == REF_COUNT * TICK_CYCLES - 1;
    endproperty
    a_nav_spacing: assert property (p_nav_spacing) else $error("ref spacing wrong");
    property p_latch_cause;
        $changed(latched_gimbal) |-> nav_cycle_start;
    endproperty
    a_latch_cause: assert property (p_latch_cause) else $error("latch moved late");
    property p_rates_cause;
        $changed(body_rates) |-> rates_valid;
    endproperty
    a_rates_cause: assert property (p_rates_cause) else $error("rates without pulse");
    property p_frozen_sticky;
        normal_frozen |=> normal_frozen;
    endproperty
    a_frozen_sticky: assert property (p_frozen_sticky) else $error("freeze dropped");
    property p_frozen_hold;
        $past(normal_frozen) |-> $stable(traj_normal);
    endproperty
    a_frozen_hold: assert property (p_frozen_hold) else $error("frozen normal moved");
    property p_att_cause;
        $changed(attitude) |->
            ($past(rates_valid) && !$past(autopilot_standby, 2)) || $past(fresh_valid);
    endproperty
    a_att_cause: assert property (p_att_cause) else $error("attitude moved alone");
endmodule
bind body_rate_attitude_estimator estimator_props #(
    .TICK_CYCLES(TICK_CYCLES), .REF_COUNT(REF_COUNT)) u_estimator_props (
    .core_clk(core_clk), .rstn(rstn), .autopilot_standby(autopilot_standby),
    .fresh_valid(fresh_valid), .nav_cycle_start(nav_cycle_start),
    .latched_gimbal(latched_gimbal), .body_rates(body_rates), .rates_valid(rates_valid),
    .attitude(attitude), .traj_normal(traj_normal), .normal_frozen(normal_frozen));

// *** sim/nav_state_model.sv ***
// Purpose: navigation side, answers each read instant with a fresh state
// Assumes: nav_cycle_start is a one-cycle pulse
// Notes:   answer alternates prompt and aligned with the next integration
`timescale 1ns/1ns
module nav_state_model
    import attitude_estimator_pkg::*;
#(
    parameter int TICK_CYCLES = 32
) (
    input  wire logic   core_clk,
    input  wire logic   rstn,
    input  wire logic   nav_cycle_start,
    output logic        fresh_valid,
    output attitude_t   fresh_angles,
    output logic [15:0] rel_velocity_mag,
    output vec3_t       traj_normal_in
);
    int          seed = 40749;
    int          wait_cnt;
    logic        slow;
    logic [15:0] vel;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fresh_valid      <= 1'b0;
            fresh_angles     <= 48'h0;
            rel_velocity_mag <= 16'h0000;
            traj_normal_in   <= 48'h0;
            wait_cnt         <= 0;
            slow             <= 1'b0;
            vel              <= 16'h07D0;
        end else begin
            fresh_valid <= (wait_cnt == 1);
            if (nav_cycle_start) begin
                wait_cnt <= slow ? TICK_CYCLES + 2 : 1;
                slow     <= ~slow;
            end else if (wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
            end
            if (wait_cnt == 1) begin
                fresh_angles     <= {16'($random(seed)), 32'h0000_0000};
                rel_velocity_mag <= vel;
                vel              <= vel - 16'h01F4;
                traj_normal_in   <= {$random(seed), 16'($random(seed))};
            end else begin
                // idle lines carry no stale copy
                fresh_angles     <= ~fresh_angles;
                rel_velocity_mag <= ~rel_velocity_mag;
                traj_normal_in   <= ~traj_normal_in;
            end
        end
    end
endmodule

// *** sim/body_rate_attitude_estimator_tb.sv ***
// Purpose: self-checking bench for the estimator
// Assumes: only the outer gimbal moves, inner and middle stay at zero
// Notes:   short tick and reference counts keep the run brief
`timescale 1ns/1ns
module body_rate_attitude_estimator_tb
    import attitude_estimator_pkg::*;
;
    localparam int TICKS = 32;
    localparam int REFS  = 5;
    localparam int GMIN  = GAMMA_MIN_DEFAULT;
    logic        core_clk;
    logic        rstn;
    gimbal_t     gimbal;
    logic        autopilot_standby;
    logic        fresh_valid;
    attitude_t   fresh_angles;
    logic [15:0] rel_velocity_mag;
    vec3_t       traj_normal_in;
    incr_t       gamma_dot;
    incr_t       roll_attitude_error;
    logic        nav_cycle_start;
    gimbal_t     latched_gimbal;
    body_rate_t  body_rates;
    logic        rates_valid;
    attitude_t   attitude;
    vec3_t       traj_normal;
    logic        normal_frozen;
    incr_t       roll_attitude_gain;
    incr_t       roll_attitude_action;
    incr_t       yaw_coord_error;
    int          miscompares = 0;
    int          compares = 0;
    int          seed = 40749;
    int          n = 0;
    int          age = 0;
    int          raw, avg, gd, s_trim;
    int          prev_raw = 0;
    logic [15:0] exp_roll = 16'h0000;
    logic [15:0] since = 16'h0000;
    logic [15:0] g_prev = 16'h0000;
    logic [15:0] integ, exp_p;
    incr_t       last_roll;
    vec3_t       exp_norm = 48'h0;
    logic        exp_frozen = 1'b0;

    body_rate_attitude_estimator #(.TICK_CYCLES(TICKS), .REF_COUNT(REFS))
    u_body_rate_attitude_estimator (
        .core_clk(core_clk), .rstn(rstn), .gimbal(gimbal),
        .autopilot_standby(autopilot_standby), .fresh_valid(fresh_valid),
        .fresh_angles(fresh_angles), .rel_velocity_mag(rel_velocity_mag),
        .traj_normal_in(traj_normal_in), .gamma_dot(gamma_dot),
        .roll_attitude_error(roll_attitude_error), .nav_cycle_start(nav_cycle_start),
        .latched_gimbal(latched_gimbal), .body_rates(body_rates), .rates_valid(rates_valid),
        .attitude(attitude), .traj_normal(traj_normal), .normal_frozen(normal_frozen),
        .roll_attitude_gain(roll_attitude_gain), .roll_attitude_action(roll_attitude_action),
        .yaw_coord_error(yaw_coord_error));
    nav_state_model #(.TICK_CYCLES(TICKS)) u_nav_state_model (
        .core_clk(core_clk), .rstn(rstn), .nav_cycle_start(nav_cycle_start),
        .fresh_valid(fresh_valid), .fresh_angles(fresh_angles),
        .rel_velocity_mag(rel_velocity_mag), .traj_normal_in(traj_normal_in));

    function automatic int sinq(input angle_t a);
        int v;
        v = (int'(a[14:0]) * (32768 - int'(a[14:0]))) >>> 14;
        return a[15] ? -v : v;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        compares++;
        if (got !== want) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (rstn) begin
            chk({16'h0000, attitude}, {16'h0000, exp_roll, 32'h0});
            chk({15'h0, normal_frozen, traj_normal}, {15'h0, exp_frozen, exp_norm});
            integ = (rates_valid && !autopilot_standby) ? body_rates.roll : 16'h0000;
            if (nav_cycle_start) begin
                since = 16'h0000;
                chk({16'h0000, latched_gimbal}, {16'h0000, gimbal});
            end
            if (fresh_valid) begin
                exp_roll = fresh_angles.roll + since;
                if (!exp_frozen && rel_velocity_mag < VEL_FREEZE_FPS) begin
                    exp_frozen = 1'b1;
                end else if (!exp_frozen) begin
                    exp_norm = traj_normal_in;
                end
            end
            exp_roll = exp_roll + integ;
            since = since + integ;
            age = age + 1;
            if (age == 10 && n > 0) begin
                chk(64'(yaw_coord_error), 64'(16'(-((int'(last_roll) * s_trim) >>> 14))));
                chk(64'(roll_attitude_gain), 64'(16'h4000));
                chk(64'(roll_attitude_action), 64'(roll_attitude_error));
            end
            if (rates_valid) begin
                raw = incr_t'(gimbal.outer - g_prev);
                avg = raw + ((raw - prev_raw) >>> 1);
                prev_raw = raw;
                g_prev = gimbal.outer;
                gd = gamma_dot;
                exp_p = (gd > GMIN || -gd > GMIN) ? 16'(-gd) : 16'h0000;
                chk(64'(body_rates), {16'h0, avg[15:0], exp_p, 16'h0});
                n = n + 1;
                age = 0;
                last_roll = avg[15:0];
                gimbal <= {16'($random(seed)), 32'h0000_0000};
                roll_attitude_error <= 16'($random(seed));
                gamma_dot <= incr_t'((n == 1) ? GMIN + 1 : (n == 2) ? -GMIN - 1 : 0);
                autopilot_standby <= (n < 4) || (n % 7 == 0);
            end
        end
    end

    initial begin
        rstn = 1'b0;
        gimbal = 48'h0;
        autopilot_standby = 1'b1;
        gamma_dot = GAMMA_MIN_DEFAULT;
        roll_attitude_error = 16'h0000;
        s_trim = sinq(ALPHA_TRIM_DEFAULT);
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 3000 && n < 40; i++) @(posedge core_clk);
        if (n < 40) begin
            miscompares++;
        end
        end_of_test();
    end
endmodule
